// File: core/twrp_pkg.sv
// Constants, types and decode helpers for the three-wire register port
package twrp_pkg;

    // Frame layout
    localparam int ADDR_BITS         = 4;
    localparam int DATA_MAX          = 32;
    localparam logic [5:0] INVALID_HIGH_BITS = 6'h20;
    localparam logic [5:0] DCNT_SAT  = 6'h3F;
    localparam logic [2:0] RW_SLOT   = 3'h4;
    localparam logic       RW_WRITE  = 1'b1;

    typedef logic [3:0]        twrp_addr_t;
    typedef logic [15:0][31:0] twrp_words_t;

    typedef enum logic [1:0] {ST_ADDR, ST_WRITE, ST_READ, ST_DONE} twrp_state_e;

    // Register addresses
    localparam twrp_addr_t A_FREQ0 = 4'h0;
    localparam twrp_addr_t A_FREQ1 = 4'h1;
    localparam twrp_addr_t A_FREQ2 = 4'h2;
    localparam twrp_addr_t A_FREQ3 = 4'h3;
    localparam twrp_addr_t A_MAIN  = 4'h4;
    localparam twrp_addr_t A_STAT  = 4'h5;
    localparam twrp_addr_t A_SLICE = 4'h6;
    localparam twrp_addr_t A_WCTL  = 4'h7;
    localparam twrp_addr_t A_WRATE = 4'h8;
    localparam twrp_addr_t A_WADDR = 4'h9;
    localparam twrp_addr_t A_WDATA = 4'hA;
    localparam twrp_addr_t A_SOFT  = 4'hB;
    localparam twrp_addr_t A_AUX   = 4'hF;

    // Reset values (all others clear)
    localparam logic [31:0] MAIN_CONTROL_RST = 32'h10000270;
    localparam logic [31:0] SLICER_TRIM_RST  = 32'h00000020;

    // Main control field positions
    localparam int MC_CHIP_ACTIVE  = 31;
    localparam int MC_DIR_SELECT   = 30;
    localparam int MC_RECCLK_EN    = 29;
    localparam int MC_TX_GATE_LOCK = 28;
    localparam int MC_AMP_ACTIVE   = 27;
    localparam int MC_WAKE_ENABLE  = 26;
    localparam int MC_FRONT_GAIN   = 25;
    localparam int MC_MEAS_SUPPLY  = 24;
    localparam int MC_LEVEL_THR    = 18;
    localparam int MC_LEVEL_HYST   = 15;
    localparam int MC_TX_POWER     = 12;
    localparam int MC_TX_PAIR      = 11;
    localparam int MC_RX_FREQ      = 8;
    localparam int MC_REF_OSC      = 7;
    localparam int MC_DISCRIM_BW   = 6;
    localparam int MC_DEMOD_POL    = 5;
    localparam int MC_SLICER_REF   = 4;
    localparam int MC_OFFSET_MEAS  = 1;

    // Implemented length of each address, zero for the absent addresses 1100 to 1110
    function automatic logic [5:0] reg_len(input twrp_addr_t a);
        unique case (a)
            A_STAT:  reg_len = 6'h1F;
            A_SLICE: reg_len = 6'h06;
            A_WRATE: reg_len = 6'h12;
            A_WADDR: reg_len = 6'h19;
            A_SOFT:  reg_len = 6'h01;
            4'hC, 4'hD, 4'hE: reg_len = 6'h00;
            default: reg_len = 6'h20;
        endcase
    endfunction

    function automatic logic reg_writable(input twrp_addr_t a);
        reg_writable = !(a == A_STAT || a == A_WDATA || a == A_SOFT || a == 4'hC
                         || a == 4'hD || a == 4'hE);
    endfunction

    function automatic logic reg_readable(input twrp_addr_t a);
        reg_readable = !(a == A_SOFT || a == 4'hC || a == 4'hD || a == 4'hE);
    endfunction

    function automatic logic [31:0] width_mask(input logic [5:0] len);
        if (len == 6'h20)
            width_mask = 32'hFFFFFFFF;
        else
            width_mask = (32'h00000001 << len) - 32'h00000001;
    endfunction

endpackage

// File: core/twrp_sync.sv
// Two-stage synchroniser for one pin level
`timescale 1ns/100ps
module twrp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;
    logic meta_next;
    logic q_reg;
    logic q_next;

    // First stage is read only by the second
    always_comb
    begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// File: core/twrp_regs.sv
// Register storage with registered read port and flat view of all words
`timescale 1ns/100ps
module twrp_regs (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  clear,
    input  wire logic                  we,
    input  wire twrp_pkg::twrp_addr_t  waddr,
    input  wire logic [31:0]           wdata,
    input  wire twrp_pkg::twrp_addr_t  raddr,
    output logic [31:0]                rdata,
    output twrp_pkg::twrp_words_t      words
);
    import twrp_pkg::*;
    twrp_words_t mem_reg;
    twrp_words_t mem_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Soft clear and hard reset load the same defaults
    always_comb
    begin
        mem_next = mem_reg;
        if (clear)
        begin
            mem_next         = '0;
            mem_next[A_MAIN] = MAIN_CONTROL_RST;
            mem_next[A_SLICE] = SLICER_TRIM_RST;
        end
        else if (we)
            mem_next[waddr] = wdata;
        rdata_next = mem_reg[raddr];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mem_reg          <= '0;
            mem_reg[A_MAIN]  <= MAIN_CONTROL_RST;
            mem_reg[A_SLICE] <= SLICER_TRIM_RST;
            rdata_reg        <= 32'h00000000;
        end
        else
        begin
            mem_reg   <= mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign words = mem_reg;
endmodule

// File: core/twrp_port.sv
// Three-wire serial register port with control outputs
`timescale 1ns/100ps

// Behaviour
// - Frame runs while enable is low; one register per frame; idle pins ignored.
// - Frame is 4 address bits, select bit, up to 32 data bits, MSB first.
// - Short data fields line up with the register's most significant bit.
// - Select 1 writes; all bits sampled on serial clock rising edges.
// - Short writes replace only supplied upper bits; low bits keep their value.
// - Data bits beyond the register length are dropped.
// - Writes within length commit when enable rises.
// - Over-length writes commit on the first rising edge past the length.
// - Select 0 reads; data changes on falling edges, MSB first.
// - Data pin turns to output on the edge after the select capture.
// - Reading past the register length drives the data line low.
// - Invalid address reads give 32 ones then zeros.
// - Data pin released as soon as enable returns high.
// - Address 0110 is a 6-bit read/write slicer trim register.
// - Address 1000 is an 18-bit wake rate register; 1100 to 1110 absent.
// - Address 1111 is a 32-bit read/write auxiliary control register.
// - Any write to address 1011 restores defaults, resets wake and recovery, powers down.
// - The reset register cannot be read.
// - Power-down holds synthesizer, recovery, lock, level and discriminator clock in reset.
// - Main control bit 31 low powers the chip down; resets low.
// - Main control bit 30 selects receive at 0, transmit at 1.
// - Main control bit 28 set gates transmission on PLL lock; resets set.
module twrp_port (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        SERIAL_CLK,
    input  wire logic        FRAME_ENABLE_N,
    input  wire logic        SERIAL_DATA_IO_IN,
    output logic             SERIAL_DATA_IO_OUT,
    output logic             SERIAL_DATA_IO_OE,
    input  wire logic        PLL_LOCK,
    input  wire logic [30:0] STATUS_IN,
    input  wire logic [31:0] WAKE_RX_DATA_IN,
    output logic             CHIP_ACTIVE,
    output logic             DIR_SELECT,
    output logic             RECOVERED_CLK_EN,
    output logic             TX_GATE_ON_LOCK,
    output logic             AMP_ACTIVE,
    output logic             WAKE_ENABLE,
    output logic             FRONT_GAIN_SEL,
    output logic             MEASURE_SUPPLY_SEL,
    output logic [5:0]       LEVEL_THRESHOLD,
    output logic [2:0]       LEVEL_HYSTERESIS,
    output logic [2:0]       TX_POWER_LEVEL,
    output logic             TX_FREQ_PAIR_SEL,
    output logic [1:0]       RX_FREQ_SEL,
    output logic             REF_OSC_SEL,
    output logic             DISCRIM_BW_SEL,
    output logic             DEMOD_POLARITY,
    output logic             SLICER_REF_SEL,
    output logic             OFFSET_MEASURE_SEL,
    output logic [5:0]       SLICER_TRIM,
    output logic [31:0]      WAKE_CONTROL,
    output logic [17:0]      WAKE_RATE,
    output logic [24:0]      WAKE_MATCH_ADDR,
    output logic [31:0]      AUX_CONTROL,
    output logic [31:0]      ACTIVE_FREQ_CODE,
    output logic             TX_ENABLE,
    output logic             PD_HOLD,
    output logic             CLKREC_RESET,
    output logic             WAKE_RESET
);
    // Frame constants and register helpers
    import twrp_pkg::*;
    // Synchronised pins and their delayed copies
    logic        sck_s;
    logic        en_s;
    logic        sd_s;
    logic        pll_s;
    logic        sck_d_reg;
    logic        en_d_reg;

    // Frame state
    twrp_state_e state_reg;
    twrp_state_e state_next;
    logic [2:0]  acnt_reg;
    logic [2:0]  acnt_next;
    logic [5:0]  dcnt_reg;
    logic [5:0]  dcnt_next;
    twrp_addr_t  addr_reg;
    twrp_addr_t  addr_next;
    logic [31:0] buf_reg;
    logic [31:0] buf_next;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] rd_word_reg;
    logic [31:0] rd_word_next;
    logic        sdo_reg;
    logic        sdo_next;
    logic        oe_reg;
    logic        oe_next;
    logic        soft_reg;
    logic        soft_next;

    // Derived outputs
    logic        tx_reg;
    logic        tx_next;
    logic        hold_reg;
    logic        hold_next;
    logic        clkrec_reg;
    logic        clkrec_next;
    logic [31:0] freq_reg;
    logic [31:0] freq_next;

    // Combinational helpers
    logic        frame_act;
    logic        rise_ev;
    logic        fall_ev;
    logic        end_ev;
    logic [5:0]  cur_len;
    logic [4:0]  bit_idx;
    logic        commit_ev;
    logic        wr_ok;
    logic        wr_en;
    logic [31:0] wr_word;
    logic [31:0] rd_src;
    logic [31:0] rd_data;
    logic        rd_bit;
    twrp_words_t words;
    logic [31:0] main_w;

    twrp_sync #(.RST_VAL(1'b0)) u_sync_sck (
        .CLK (CLK),
        .RST (RST),
        .d   (SERIAL_CLK),
        .q   (sck_s)
    );
    twrp_sync #(.RST_VAL(1'b1)) u_sync_en (
        .CLK (CLK),
        .RST (RST),
        .d   (FRAME_ENABLE_N),
        .q   (en_s)
    );
    twrp_sync #(.RST_VAL(1'b0)) u_sync_sd (
        .CLK (CLK),
        .RST (RST),
        .d   (SERIAL_DATA_IO_IN),
        .q   (sd_s)
    );
    twrp_sync #(.RST_VAL(1'b0)) u_sync_pll (
        .CLK (CLK),
        .RST (RST),
        .d   (PLL_LOCK),
        .q   (pll_s)
    );

    // Register storage; soft reset pulse follows commit by one cycle and clears it on the next edge
    twrp_regs u_regs (
        .CLK   (CLK),
        .RST   (RST),
        .clear (soft_reg),
        .we    (wr_en),
        .waddr (addr_reg),
        .wdata (wr_word),
        .raddr (addr_reg),
        .rdata (rd_data),
        .words (words)
    );

    assign main_w = words[A_MAIN];

    // edges only count inside a frame
    always_comb
    begin
        frame_act = !en_s;
        rise_ev   = frame_act && sck_s && !sck_d_reg;
        fall_ev   = frame_act && !sck_s && sck_d_reg;
        end_ev    = en_s && !en_d_reg;
    end

    // data bit k maps to register bit len-1-k
    always_comb
    begin
        cur_len = reg_len(addr_reg);
        bit_idx = 5'(cur_len - 6'h01 - dcnt_reg);
        wr_ok   = reg_writable(addr_reg);
    end

    // or at first extra rising edge
    always_comb
    begin
        commit_ev = (state_reg == ST_WRITE)
                    && (end_ev || (rise_ev && dcnt_reg == cur_len));
        // read-only and reserved targets never written
        wr_en     = commit_ev && wr_ok;
        // merge supplied upper bits over old contents
        wr_word   = ((words[addr_reg] & ~mask_reg) | (buf_reg & mask_reg))
                    & width_mask(cur_len);
    end

    // Read source: status and wake data come from live inputs
    always_comb
    begin
        if (addr_reg == A_STAT)
            rd_src = {1'b0, STATUS_IN};
        else if (addr_reg == A_WDATA)
            rd_src = WAKE_RX_DATA_IN;
        else
            rd_src = rd_data;
    end

    // zero past the length; invalid pattern
    always_comb
    begin
        if (reg_readable(addr_reg))
            rd_bit = (dcnt_reg < cur_len) ? rd_word_reg[bit_idx] : 1'b0;
        else
            rd_bit = (dcnt_reg < INVALID_HIGH_BITS);
    end

    // Frame sequencer: address, select, then write or read data
    always_comb
    begin
        state_next   = state_reg;
        acnt_next    = acnt_reg;
        dcnt_next    = dcnt_reg;
        addr_next    = addr_reg;
        buf_next     = buf_reg;
        mask_next    = mask_reg;
        rd_word_next = rd_word_reg;
        sdo_next     = sdo_reg;
        oe_next      = oe_reg;
        // any write to the reset address fires the pulse
        soft_next    = commit_ev && (addr_reg == A_SOFT);
        if (!frame_act)
        begin
            // release pin while enable is high
            state_next = ST_ADDR;
            acnt_next  = 3'h0;
            dcnt_next  = 6'h00;
            oe_next    = 1'b0;
            sdo_next   = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_ADDR:
                begin
                    if (rise_ev && acnt_reg < RW_SLOT)
                    begin
                        addr_next = {addr_reg[2:0], sd_s};
                        acnt_next = acnt_reg + 3'h1;
                    end
                    else if (rise_ev)
                    begin
                        dcnt_next = 6'h00;
                        buf_next  = 32'h00000000;
                        mask_next = 32'h00000000;
                        if (sd_s == RW_WRITE)
                            state_next = ST_WRITE;
                        else
                        begin
                            state_next   = ST_READ;
                            rd_word_next = rd_src;
                        end
                    end
                end
                ST_WRITE:
                begin
                    // commit happens here, rest of frame ignored
                    if (rise_ev && dcnt_reg == cur_len)
                        state_next = ST_DONE;
                    else if (rise_ev)
                    begin
                        buf_next[bit_idx]  = sd_s;
                        mask_next[bit_idx] = 1'b1;
                        dcnt_next          = dcnt_reg + 6'h01;
                    end
                end
                ST_READ:
                begin
                    // drive from the falling edge after the select
                    if (fall_ev)
                    begin
                        oe_next  = 1'b1;
                        sdo_next = rd_bit;
                        if (dcnt_reg != DCNT_SAT)
                            dcnt_next = dcnt_reg + 6'h01;
                    end
                end
                ST_DONE:
                begin
                    state_next = ST_DONE;
                end
            endcase
        end
    end

    // Derived chip controls, registered to keep outputs glitch-free
    always_comb
    begin
        tx_next = main_w[MC_CHIP_ACTIVE] && main_w[MC_DIR_SELECT]
                  && main_w[MC_AMP_ACTIVE] && (!main_w[MC_TX_GATE_LOCK] || pll_s);
        hold_next   = !main_w[MC_CHIP_ACTIVE];
        clkrec_next = !main_w[MC_CHIP_ACTIVE] || soft_reg;
        if (main_w[MC_DIR_SELECT])
            freq_next = main_w[MC_TX_PAIR] ? words[A_FREQ2] : words[A_FREQ0];
        else
            freq_next = words[{2'b00, main_w[MC_RX_FREQ +: 2]}];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sck_d_reg   <= 1'b0;
            en_d_reg    <= 1'b1;
            state_reg   <= ST_ADDR;
            acnt_reg    <= 3'h0;
            dcnt_reg    <= 6'h00;
            addr_reg    <= 4'h0;
            buf_reg     <= 32'h00000000;
            mask_reg    <= 32'h00000000;
            rd_word_reg <= 32'h00000000;
            sdo_reg     <= 1'b0;
            oe_reg      <= 1'b0;
            soft_reg    <= 1'b0;
            tx_reg      <= 1'b0;
            hold_reg    <= 1'b1;
            clkrec_reg  <= 1'b1;
            freq_reg    <= 32'h00000000;
        end
        else
        begin
            sck_d_reg   <= sck_s;
            en_d_reg    <= en_s;
            state_reg   <= state_next;
            acnt_reg    <= acnt_next;
            dcnt_reg    <= dcnt_next;
            addr_reg    <= addr_next;
            buf_reg     <= buf_next;
            mask_reg    <= mask_next;
            rd_word_reg <= rd_word_next;
            sdo_reg     <= sdo_next;
            oe_reg      <= oe_next;
            soft_reg    <= soft_next;
            tx_reg      <= tx_next;
            hold_reg    <= hold_next;
            clkrec_reg  <= clkrec_next;
            freq_reg    <= freq_next;
        end
    end

    // Pin and control outputs; register fields come straight from storage flops
    assign SERIAL_DATA_IO_OUT = sdo_reg;
    assign SERIAL_DATA_IO_OE  = oe_reg;
    assign CHIP_ACTIVE        = main_w[MC_CHIP_ACTIVE];
    assign DIR_SELECT         = main_w[MC_DIR_SELECT];
    assign RECOVERED_CLK_EN   = main_w[MC_RECCLK_EN];
    assign TX_GATE_ON_LOCK    = main_w[MC_TX_GATE_LOCK];
    assign AMP_ACTIVE         = main_w[MC_AMP_ACTIVE];
    assign WAKE_ENABLE        = main_w[MC_WAKE_ENABLE];
    assign FRONT_GAIN_SEL     = main_w[MC_FRONT_GAIN];
    assign MEASURE_SUPPLY_SEL = main_w[MC_MEAS_SUPPLY];
    assign LEVEL_THRESHOLD    = main_w[MC_LEVEL_THR +: 6];
    assign LEVEL_HYSTERESIS   = main_w[MC_LEVEL_HYST +: 3];
    assign TX_POWER_LEVEL     = main_w[MC_TX_POWER +: 3];
    assign TX_FREQ_PAIR_SEL   = main_w[MC_TX_PAIR];
    assign RX_FREQ_SEL        = main_w[MC_RX_FREQ +: 2];
    assign REF_OSC_SEL        = main_w[MC_REF_OSC];
    assign DISCRIM_BW_SEL     = main_w[MC_DISCRIM_BW];
    assign DEMOD_POLARITY     = main_w[MC_DEMOD_POL];
    assign SLICER_REF_SEL     = main_w[MC_SLICER_REF];
    assign OFFSET_MEASURE_SEL = main_w[MC_OFFSET_MEAS];
    assign SLICER_TRIM        = words[A_SLICE][5:0];
    assign WAKE_CONTROL       = words[A_WCTL];
    assign WAKE_RATE          = words[A_WRATE][17:0];
    assign WAKE_MATCH_ADDR    = words[A_WADDR][24:0];
    assign AUX_CONTROL        = words[A_AUX];
    assign ACTIVE_FREQ_CODE   = freq_reg;
    assign TX_ENABLE          = tx_reg;
    assign PD_HOLD            = hold_reg;
    assign CLKREC_RESET       = clkrec_reg;
    assign WAKE_RESET         = soft_reg;

    // Checks on the frame engine and derived controls
    a_oe_released: assert property (@(posedge CLK) disable iff (RST)
        en_s |=> !oe_reg)
        else $error("data pin still driven with enable high");
    a_oe_turnaround: assert property (@(posedge CLK) disable iff (RST)
        $rose(oe_reg) |-> $past(state_reg == ST_READ && fall_ev))
        else $error("data pin turned without a read falling edge");
    a_commit_lands: assert property (@(posedge CLK) disable iff (RST)
        wr_en |=> words[$past(addr_reg)] == $past(wr_word))
        else $error("committed word not stored");
    a_over_commit: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == ST_WRITE && rise_ev && dcnt_reg == cur_len)
        |-> commit_ev ##1 state_reg == ST_DONE)
        else $error("over-length write not committed at extra edge");
    a_done_no_write: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == ST_DONE && !soft_reg) |=> $stable(words))
        else $error("extra bits caused a second write");
    a_read_clamp: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == ST_READ && fall_ev && reg_readable(addr_reg)
         && dcnt_reg >= cur_len) |=> !sdo_reg && oe_reg)
        else $error("read past length not driven low");
    a_invalid_high: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == ST_READ && fall_ev && !reg_readable(addr_reg))
        |=> sdo_reg == ($past(dcnt_reg) < INVALID_HIGH_BITS))
        else $error("invalid address pattern wrong");
    a_ro_unchanged: assert property (@(posedge CLK) disable iff (RST)
        (commit_ev && !wr_ok && addr_reg != A_SOFT) |=> $stable(words))
        else $error("write to protected address changed storage");
    a_soft_defaults: assert property (@(posedge CLK) disable iff (RST)
        (commit_ev && addr_reg == A_SOFT) |=> WAKE_RESET ##1
        (main_w == MAIN_CONTROL_RST && !CHIP_ACTIVE) ##1 PD_HOLD)
        else $error("soft reset did not restore defaults");
    a_tx_lock_gate: assert property (@(posedge CLK) disable iff (RST)
        (!pll_s && main_w[MC_TX_GATE_LOCK]) |=> !TX_ENABLE)
        else $error("transmit enabled without lock");
endmodule

// File: tb/twrp_host.sv
// Host model that drives frames on the three-wire pins
`timescale 1ns/100ps
module twrp_host (
    input  wire logic CLK,
    input  wire logic line,
    output logic      sck,
    output logic      le_n,
    output logic      hd
);
    initial {sck, le_n, hd} = 3'h2;
    task automatic xfer(input logic [3:0] a, input logic w, input int n,
                        input logic [31:0] d, output logic [31:0] q);
        logic [36:0] s;
        s = {a, w, d};
        q = 32'h00000000;
        @(posedge CLK) le_n <= 1'b0;
        for (int i = 0; i < 5 + n; i++)
        begin
            repeat (5) @(posedge CLK);
            // Released line toggles so a stale level is never read back
            hd <= (i < 5 || w) ? s[36] : ~hd;
            s = {s[35:0], 1'b0};
            repeat (5) @(posedge CLK);
            sck <= 1'b1;
            if (i > 4)
                q = {q[30:0], line};
            repeat (5) @(posedge CLK);
            sck <= 1'b0;
        end
        repeat (5) @(posedge CLK);
        le_n <= 1'b1;
        repeat (10) @(posedge CLK);
    endtask
endmodule

// File: tb/twrp_port_tb_top.sv
// Self-checking bench for the three-wire register port
`timescale 1ns/100ps
module twrp_port_tb_top;
    import twrp_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, lock = 1'b0;
    logic        sck, le_n, hd, dout, oe, act, pdh, txe;
    logic [5:0]  trim;
    logic [31:0] aux, q;
    int          mismatches = 0, tests_run = 0;
    // Device wins the wire while it drives
    wire line = oe ? dout : hd;
    always #5 clk = ~clk;
    twrp_host u_twrp_host (.CLK(clk), .line(line), .sck(sck), .le_n(le_n), .hd(hd));
    twrp_port u_twrp_port (.CLK(clk), .RST(rst), .SERIAL_CLK(sck), .FRAME_ENABLE_N(le_n),
        .SERIAL_DATA_IO_IN(line), .SERIAL_DATA_IO_OUT(dout), .SERIAL_DATA_IO_OE(oe),
        .PLL_LOCK(lock), .STATUS_IN(31'h00000000), .WAKE_RX_DATA_IN(32'h00000000),
        .CHIP_ACTIVE(act), .DIR_SELECT(), .RECOVERED_CLK_EN(), .TX_GATE_ON_LOCK(),
        .AMP_ACTIVE(), .WAKE_ENABLE(), .FRONT_GAIN_SEL(), .MEASURE_SUPPLY_SEL(),
        .LEVEL_THRESHOLD(), .LEVEL_HYSTERESIS(), .TX_POWER_LEVEL(), .TX_FREQ_PAIR_SEL(),
        .RX_FREQ_SEL(), .REF_OSC_SEL(), .DISCRIM_BW_SEL(), .DEMOD_POLARITY(),
        .SLICER_REF_SEL(), .OFFSET_MEASURE_SEL(), .SLICER_TRIM(trim), .WAKE_CONTROL(),
        .WAKE_RATE(), .WAKE_MATCH_ADDR(), .AUX_CONTROL(aux), .ACTIVE_FREQ_CODE(),
        .TX_ENABLE(txe), .PD_HOLD(pdh), .CLKREC_RESET(), .WAKE_RESET());
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input int n, input logic [31:0] d);
        u_twrp_host.xfer(a, 1'b1, n, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input int n);
        u_twrp_host.xfer(a, 1'b0, n, 32'h00000000, q);
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Two cycles of reset; pins already sit at the sync chains' reset levels
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        rd(A_MAIN, 32);
        chk("main", q, MAIN_CONTROL_RST);
        chk("pdhold", 32'(pdh), 32'h00000001);
        chk("oe", 32'(oe), 32'h00000000);
        rd(A_SLICE, 10);
        chk("trim_rd", q, 32'h00000200);
        wr(A_FREQ1, 32, 32'h12345678);
        rd(A_FREQ1, 32);
        chk("f1", q, 32'h12345678);
        wr(A_FREQ1, 8, 32'hAB000000);
        rd(A_FREQ1, 32);
        chk("f1_part", q, 32'hAB345678);
        rd(A_FREQ1, 4);
        chk("f1_trunc", q, 32'h0000000A);
        wr(A_SLICE, 10, 32'h9FC00000);
        chk("trim_wr", 32'(trim), 32'h00000027);
        wr(A_WRATE, 18, 32'hFFFFC000);
        rd(A_WRATE, 18);
        chk("rate", q, 32'h0003FFFF);
        wr(A_AUX, 32, 32'h0F0F0F0F);
        wr(4'hC, 32, 32'hFFFFFFFF);
        wr(A_STAT, 32, 32'hFFFFFFFF);
        chk("aux", aux, 32'h0F0F0F0F);
        rd(4'hC, 34);
        chk("bad_addr", q, 32'hFFFFFFFC);
        // Active, transmit, lock gating kept on, amplifier on
        wr(A_MAIN, 5, 32'hD8000000);
        chk("active", 32'(act), 32'h00000001);
        chk("tx_nolock", 32'(txe), 32'h00000000);
        lock <= 1'b1;
        repeat (8) @(posedge clk);
        chk("tx_lock", 32'(txe), 32'h00000001);
        wr(A_SOFT, 0, 32'h00000000);
        repeat (1000) @(posedge clk);
        chk("pd_soft", 32'(pdh), 32'h00000001);
        chk("aux_soft", aux, 32'h00000000);
        rd(A_MAIN, 32);
        chk("main_soft", q, MAIN_CONTROL_RST);
        print_verdict;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict;
    end
endmodule
